// File: common/dsp_pkg.sv
// Constants shared by the dual-slope PWM waveform unit and its channels.
// Assumes a 32-bit Avalon-MM slave with byte addresses, 8-bit registers.
package dsp_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL_A = 5'h00;
  localparam logic [4:0] OFS_CTRL_B = 5'h04;
  localparam logic [4:0] OFS_COUNT = 5'h08;
  localparam logic [4:0] OFS_CMP_A = 5'h0c;
  localparam logic [4:0] OFS_CMP_B = 5'h10;
  localparam logic [4:0] OFS_FLAGS = 5'h14;
  localparam logic [4:0] OFS_PINS = 5'h18;
  // Field positions
  localparam int OUT_A_LSB = 6;
  localparam int OUT_B_LSB = 4;
  localparam int WGM_LO_LSB = 0;
  localparam int WGM_HI_BIT = 3;
  localparam int CS_LSB = 0;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int OVF_BIT = 0;
  localparam int MATCH_A_BIT = 1;
  localparam int MATCH_B_BIT = 2;
  localparam int DIR_A_BIT = 0;
  localparam int DIR_B_BIT = 1;
  localparam int PORT_A_BIT = 4;
  localparam int PORT_B_BIT = 5;
  // Reset and counter limits
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hff;
  // Waveform generation selections
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_DUAL_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_DUAL_OCR = 3'h5;
  localparam logic [2:0] WGM_FAST_OCR = 3'h7;
  // Output mode codes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  // Ticks per dual-slope period with TOP at MAX
  localparam int DUAL_PERIOD_TICKS = 510;
  typedef enum logic {DIR_DOWN = 1'b0, DIR_UP = 1'b1} dsp_dir_t;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} dsp_bus_t;
endpackage

// File: rtl/dsp_chan.sv
// One compare channel: compare buffer, match detect, waveform register.
// Assumes count, direction and tick come from the top on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dsp_chan #(
  parameter bit IS_A = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic tick_in,
  input wire logic [7:0] count_in,
  input wire logic [7:0] top_in,
  input wire logic dir_up_in,
  input wire logic [2:0] wgm_in,
  input wire logic [1:0] out_mode_in,
  input wire logic cmp_wr_in,
  input wire logic [7:0] cmp_data_in,
  input wire logic force_in,
  output logic [7:0] cmp_sw_out,
  output logic [7:0] cmp_buf_out,
  output logic wave_out,
  output logic connected_out,
  output logic match_out
);
  import dsp_pkg::*;
  logic [7:0] cmp_sw_q, cmp_sw_d; // Software-visible compare value
  logic [7:0] cmp_buf_q, cmp_buf_d; // Compare value in use
  logic wave_q, wave_d; // Waveform register
  logic up_hit_q, up_hit_d; // Up-slope match seen since BOTTOM
  logic is_dual, is_fast, is_pwm, at_top, at_bot, hit, going_up, ign, tog_ok, inv;

  // Match decode and waveform next state
  always_comb
  begin
    is_dual = (wgm_in == WGM_DUAL_MAX) || (wgm_in == WGM_DUAL_OCR);
    is_fast = (wgm_in == WGM_FAST_MAX) || (wgm_in == WGM_FAST_OCR);
    is_pwm = is_dual || is_fast;
    at_top = count_in == top_in;
    at_bot = count_in == BOTTOM_VAL;
    hit = tick_in && (count_in == cmp_buf_q);
    going_up = dir_up_in || at_bot;
    ign = is_pwm && out_mode_in[1] && (cmp_buf_q == top_in);
    tog_ok = !is_pwm || (IS_A && wgm_in[2]);
    inv = out_mode_in[0];
    // Detached when off, or toggle not allowed in PWM
    connected_out = (out_mode_in != OM_OFF) && ((out_mode_in != OM_TOGGLE) || tog_ok);
    cmp_sw_d = cmp_wr_in ? cmp_data_in : cmp_sw_q;
    // Immediate update outside PWM, at TOP inside it
    if (!is_pwm)
      cmp_buf_d = cmp_sw_d;
    else if (tick_in && at_top)
      cmp_buf_d = cmp_sw_q;
    else
      cmp_buf_d = cmp_buf_q;
    wave_d = wave_q;
    up_hit_d = up_hit_q;
    if (tick_in && at_bot)
      up_hit_d = 1'b0;
    if (!is_pwm)
    begin
      // Toggle, clear or set on match or forced match
      if (hit || force_in)
      begin
        case (out_mode_in)
          OM_TOGGLE: wave_d = !wave_q;
          OM_CLEAR: wave_d = 1'b0;
          OM_SET: wave_d = 1'b1;
          default: wave_d = wave_q;
        endcase
      end
    end
    else if (out_mode_in == OM_TOGGLE)
    begin
      if (hit && tog_ok)
        wave_d = !wave_q;
    end
    else if (out_mode_in[1] && is_fast)
    begin
      // Single slope: match action, opposite action at TOP
      if (hit && !ign)
        wave_d = inv;
      else if (tick_in && at_top)
        wave_d = !inv;
    end
    else if (out_mode_in[1])
    begin
      // Dual slope: direction picks the match action
      if (hit && !ign)
      begin
        wave_d = going_up ? inv : !inv;
        if (going_up)
          up_hit_d = 1'b1;
      end
      else if (tick_in && at_top && ign)
        wave_d = !inv;
      else if (tick_in && at_bot && !up_hit_q && (cmp_buf_q != top_in))
        wave_d = inv;
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cmp_sw_q <= REG_RESET;
      cmp_buf_q <= REG_RESET;
      wave_q <= 1'b0;
      up_hit_q <= 1'b0;
      match_out <= 1'b0;
    end
    else
    begin
      cmp_sw_q <= cmp_sw_d;
      cmp_buf_q <= cmp_buf_d;
      wave_q <= wave_d;
      up_hit_q <= up_hit_d;
      match_out <= hit;
    end
  end

  assign cmp_sw_out = cmp_sw_q;
  assign cmp_buf_out = cmp_buf_q;
  assign wave_out = wave_q;

  a_buffer_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    is_pwm && !(tick_in && at_top) |=> $stable(cmp_buf_q))
    else $error("compare buffer moved away from TOP");
  a_dual_up_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    is_dual && hit && !ign && dir_up_in && out_mode_in == OM_CLEAR |=> !wave_q)
    else $error("up match did not clear output");
  a_dual_down_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    is_dual && hit && !ign && !going_up && out_mode_in == OM_SET |=> !wave_q)
    else $error("down match did not clear inverted output");
  a_top_ignore: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tick_in && is_pwm && ign && at_top && out_mode_in == OM_CLEAR |=> wave_q)
    else $error("TOP action missing when compare equals TOP");
  a_plain_toggle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !is_pwm && hit && out_mode_in == OM_TOGGLE |=> wave_q != $past(wave_q))
    else $error("toggle on match missing");
  a_bottom_symmetry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    is_dual && out_mode_in[1] && tick_in && at_bot && !up_hit_q && (cmp_buf_q != top_in)
    |=> wave_q == $past(out_mode_in[0]))
    else $error("no symmetry transition at BOTTOM");
endmodule
`default_nettype wire

// File: rtl/dsp_top.sv
// Dual-slope PWM waveform unit: counter, two channels, Avalon-MM registers.
// Assumes an external prescaler tick on CLK_IN and a port pin pad outside.
`timescale 1ns/1ns
`default_nettype none
module dsp_top (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic TIMER_TICK_IN,
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  output logic [2:0] CLK_SEL_OUT,
  output logic WAVE_A_PIN_OUT,
  output logic WAVE_A_OE_OUT,
  output logic WAVE_B_PIN_OUT,
  output logic WAVE_B_OE_OUT
);
  import dsp_pkg::*;
  // Control fields
  logic [1:0] out_mode_a_q, out_mode_a_d;
  logic [1:0] out_mode_b_q, out_mode_b_d;
  logic [1:0] wgm_lo_q, wgm_lo_d;
  logic wgm_hi_q, wgm_hi_d;
  logic [2:0] clk_sel_q, clk_sel_d;
  // Counter state
  logic [7:0] count_q, count_d;
  dsp_dir_t dir_q, dir_d;
  // Sticky flags
  logic ovf_q, ovf_d, mfa_q, mfa_d, mfb_q, mfb_d;
  // Pin direction and port data
  logic dir_a_q, dir_a_d, dir_b_q, dir_b_d, port_a_q, port_a_d, port_b_q, port_b_d;
  // Bus slave state
  dsp_bus_t bus_q, bus_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  // Pin registers
  logic pin_a_q, pin_a_d, oe_a_q, oe_a_d, pin_b_q, pin_b_d, oe_b_q, oe_b_d;
  // Decode and datapath nets
  logic rd_go, wr_go, wr_ctrl_a, wr_ctrl_b, wr_count, wr_cmp_a, wr_cmp_b, wr_flags;
  logic [7:0] wd;
  logic [2:0] wgm;
  logic is_dual, is_fast, is_ctc, tick, ovf_set;
  logic [7:0] top;
  logic [7:0] cmp_a_sw, cmp_a_buf, cmp_b_sw;
  logic wave_a, wave_b, conn_a, conn_b, match_a, match_b;

  // Bus request decode
  always_comb
  begin
    rd_go = (bus_q == BUS_IDLE) && AVS_READ_IN;
    wr_go = (bus_q == BUS_IDLE) && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
    wd = AVS_WRITEDATA_IN[7:0];
    wr_ctrl_a = 1'b0;
    wr_ctrl_b = 1'b0;
    wr_count = 1'b0;
    wr_cmp_a = 1'b0;
    wr_cmp_b = 1'b0;
    wr_flags = 1'b0;
    if (!wr_go)
      wr_ctrl_a = 1'b0;
    else if (AVS_ADDRESS_IN == OFS_CTRL_A)
      wr_ctrl_a = 1'b1;
    else if (AVS_ADDRESS_IN == OFS_CTRL_B)
      wr_ctrl_b = 1'b1;
    else if (AVS_ADDRESS_IN == OFS_COUNT)
      wr_count = 1'b1;
    else if (AVS_ADDRESS_IN == OFS_CMP_A)
      wr_cmp_a = 1'b1;
    else if (AVS_ADDRESS_IN == OFS_CMP_B)
      wr_cmp_b = 1'b1;
    else if (AVS_ADDRESS_IN == OFS_FLAGS)
      wr_flags = 1'b1;
  end

  // Mode decode, TOP source and gated tick
  always_comb
  begin
    wgm = {wgm_hi_q, wgm_lo_q};
    is_dual = (wgm == WGM_DUAL_MAX) || (wgm == WGM_DUAL_OCR);
    is_fast = (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_OCR);
    is_ctc = wgm == WGM_CTC;
    if ((wgm == WGM_DUAL_OCR) || (wgm == WGM_FAST_OCR) || is_ctc)
      top = cmp_a_buf;
    else
      top = MAX_VAL;
    tick = TIMER_TICK_IN && (clk_sel_q != 3'h0);
  end

  // Counter next state
  always_comb
  begin
    count_d = count_q;
    dir_d = dir_q;
    ovf_set = 1'b0;
    if (tick && is_dual)
    begin
      if (dir_q == DIR_UP)
      begin
        // TOP was shown for this tick; now turn down
        if (count_q >= top)
        begin
          count_d = (count_q == BOTTOM_VAL) ? BOTTOM_VAL : count_q - 8'h01;
          dir_d = DIR_DOWN;
        end
        else
          count_d = count_q + 8'h01;
      end
      else if (count_q == BOTTOM_VAL)
      begin
        count_d = 8'h01;
        dir_d = DIR_UP;
      end
      else
      begin
        count_d = count_q - 8'h01;
        ovf_set = count_d == BOTTOM_VAL;
      end
    end
    else if (tick)
    begin
      // Up counting with wrap or clear at TOP
      dir_d = DIR_UP;
      if ((is_fast || is_ctc) && (count_q == top))
        count_d = BOTTOM_VAL;
      else
        count_d = count_q + 8'h01;
      ovf_set = is_fast ? (count_q == top) : (count_q == MAX_VAL);
    end
    else if (!is_dual)
      dir_d = DIR_UP;
    if (wr_count)
      count_d = wd;
  end

  // Register writes, flags and pin selection
  always_comb
  begin
    out_mode_a_d = wr_ctrl_a ? wd[OUT_A_LSB +: 2] : out_mode_a_q;
    out_mode_b_d = wr_ctrl_a ? wd[OUT_B_LSB +: 2] : out_mode_b_q;
    wgm_lo_d = wr_ctrl_a ? wd[WGM_LO_LSB +: 2] : wgm_lo_q;
    wgm_hi_d = wr_ctrl_b ? wd[WGM_HI_BIT] : wgm_hi_q;
    clk_sel_d = wr_ctrl_b ? wd[CS_LSB +: 3] : clk_sel_q;
    dir_a_d = dir_a_q;
    dir_b_d = dir_b_q;
    port_a_d = port_a_q;
    port_b_d = port_b_q;
    if (wr_go && (AVS_ADDRESS_IN == OFS_PINS))
    begin
      dir_a_d = wd[DIR_A_BIT];
      dir_b_d = wd[DIR_B_BIT];
      port_a_d = wd[PORT_A_BIT];
      port_b_d = wd[PORT_B_BIT];
    end
    // Write one clears; a set in the same cycle wins
    ovf_d = ovf_set || (ovf_q && !(wr_flags && wd[OVF_BIT]));
    mfa_d = match_a || (mfa_q && !(wr_flags && wd[MATCH_A_BIT]));
    mfb_d = match_b || (mfb_q && !(wr_flags && wd[MATCH_B_BIT]));
    // Waveform overrides port data when attached
    pin_a_d = conn_a ? wave_a : port_a_q;
    pin_b_d = conn_b ? wave_b : port_b_q;
    oe_a_d = dir_a_q;
    oe_b_d = dir_b_q;
  end

  // Bus handshake and read data
  always_comb
  begin
    bus_d = BUS_IDLE;
    wait_d = 1'b1;
    rdata_d = 32'h0;
    if ((bus_q == BUS_IDLE) && (AVS_READ_IN || AVS_WRITE_IN))
    begin
      bus_d = BUS_ACK;
      wait_d = 1'b0;
    end
    if (!rd_go)
      rdata_d = 32'h0;
    else if (AVS_ADDRESS_IN == OFS_CTRL_A)
      rdata_d = {24'h0, out_mode_a_q, out_mode_b_q, 2'b00, wgm_lo_q};
    else if (AVS_ADDRESS_IN == OFS_CTRL_B)
      rdata_d = {24'h0, 4'h0, wgm_hi_q, clk_sel_q};
    else if (AVS_ADDRESS_IN == OFS_COUNT)
      rdata_d = {24'h0, count_q};
    else if (AVS_ADDRESS_IN == OFS_CMP_A)
      rdata_d = {24'h0, cmp_a_sw};
    else if (AVS_ADDRESS_IN == OFS_CMP_B)
      rdata_d = {24'h0, cmp_b_sw};
    else if (AVS_ADDRESS_IN == OFS_FLAGS)
      rdata_d = {29'h0, mfb_q, mfa_q, ovf_q};
    else if (AVS_ADDRESS_IN == OFS_PINS)
      rdata_d = {26'h0, port_b_q, port_a_q, 2'b00, dir_b_q, dir_a_q};
  end

  // All state registers except the period helper
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      out_mode_a_q <= OM_OFF;
      out_mode_b_q <= OM_OFF;
      wgm_lo_q <= 2'h0;
      wgm_hi_q <= 1'b0;
      clk_sel_q <= 3'h0;
      count_q <= REG_RESET;
      dir_q <= DIR_UP;
      ovf_q <= 1'b0;
      mfa_q <= 1'b0;
      mfb_q <= 1'b0;
      dir_a_q <= 1'b0;
      dir_b_q <= 1'b0;
      port_a_q <= 1'b0;
      port_b_q <= 1'b0;
      bus_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      pin_a_q <= 1'b0;
      oe_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      oe_b_q <= 1'b0;
    end
    else
    begin
      out_mode_a_q <= out_mode_a_d;
      out_mode_b_q <= out_mode_b_d;
      wgm_lo_q <= wgm_lo_d;
      wgm_hi_q <= wgm_hi_d;
      clk_sel_q <= clk_sel_d;
      count_q <= count_d;
      dir_q <= dir_d;
      ovf_q <= ovf_d;
      mfa_q <= mfa_d;
      mfb_q <= mfb_d;
      dir_a_q <= dir_a_d;
      dir_b_q <= dir_b_d;
      port_a_q <= port_a_d;
      port_b_q <= port_b_d;
      bus_q <= bus_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      pin_a_q <= pin_a_d;
      oe_a_q <= oe_a_d;
      pin_b_q <= pin_b_d;
      oe_b_q <= oe_b_d;
    end
  end

  assign AVS_READDATA_OUT = rdata_q;
  assign AVS_WAITREQUEST_OUT = wait_q;
  assign CLK_SEL_OUT = clk_sel_q;
  assign WAVE_A_PIN_OUT = pin_a_q;
  assign WAVE_A_OE_OUT = oe_a_q;
  assign WAVE_B_PIN_OUT = pin_b_q;
  assign WAVE_B_OE_OUT = oe_b_q;

  // Channel A, which may also supply TOP
  dsp_chan #(.IS_A(1'b1)) u_chan_a (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .tick_in(tick),
    .count_in(count_q),
    .top_in(top),
    .dir_up_in(dir_q == DIR_UP),
    .wgm_in(wgm),
    .out_mode_in(out_mode_a_q),
    .cmp_wr_in(wr_cmp_a),
    .cmp_data_in(wd),
    .force_in(wr_ctrl_b && wd[FORCE_A_BIT]),
    .cmp_sw_out(cmp_a_sw),
    .cmp_buf_out(cmp_a_buf),
    .wave_out(wave_a),
    .connected_out(conn_a),
    .match_out(match_a)
  );

  // Channel B
  dsp_chan #(.IS_A(1'b0)) u_chan_b (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .tick_in(tick),
    .count_in(count_q),
    .top_in(top),
    .dir_up_in(dir_q == DIR_UP),
    .wgm_in(wgm),
    .out_mode_in(out_mode_b_q),
    .cmp_wr_in(wr_cmp_b),
    .cmp_data_in(wd),
    .force_in(wr_ctrl_b && wd[FORCE_B_BIT]),
    .cmp_sw_out(cmp_b_sw),
    .cmp_buf_out(),
    .wave_out(wave_b),
    .connected_out(conn_b),
    .match_out(match_b)
  );

  // Helper: ticks between overflow sets in fixed-top dual slope
  logic [9:0] per_q;
  logic per_ok_q;
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      per_q <= 10'h0;
      per_ok_q <= 1'b0;
    end
    else
    begin
      per_q <= ovf_set ? 10'h1 : (tick ? per_q + 10'h1 : per_q);
      per_ok_q <= (wgm == WGM_DUAL_MAX) && !wr_count && !wr_ctrl_a && !wr_ctrl_b
        && (per_ok_q || ovf_set);
    end
  end

  a_dual_period: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    per_ok_q && ovf_set && !wr_count |-> per_q == 10'(DUAL_PERIOD_TICKS))
    else $error("dual-slope period is not 510 ticks");
  a_top_hold: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    tick && is_dual && dir_q == DIR_UP && count_q == top && top != BOTTOM_VAL && !wr_count
    |=> dir_q == DIR_DOWN && count_q == $past(top) - 8'h01)
    else $error("counter did not turn after one tick at TOP");
  a_bottom_flag: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    tick && is_dual && dir_q == DIR_DOWN && count_q == 8'h01 && !wr_count
    |=> ovf_q && count_q == 8'h00)
    else $error("overflow flag not set at BOTTOM");
  a_pin_override: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    conn_a |=> WAVE_A_PIN_OUT == $past(wave_a) && WAVE_A_OE_OUT == $past(dir_a_q))
    else $error("waveform did not override pin A");
  a_tick_gate: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !tick && !wr_count |=> $stable(count_q))
    else $error("counter moved without a tick");
  a_bus_answer: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");
endmodule
`default_nettype wire

// File: dv/dsp_load.sv
// Load on one waveform pin: a pad with a weak pull-down.
// Assumes the unit gives pin level and output enable as separate ports.
`timescale 1ns/1ns
`default_nettype none
module dsp_load (
  input wire logic pin_in,
  input wire logic oe_in,
  output logic level_out
);
  // Pad level: driven value, else the pull-down wins
  assign level_out = oe_in ? pin_in : 1'b0;
endmodule
`default_nettype wire

// File: dv/test_dsp_top.sv
// Self-checking bench for the dual-slope PWM waveform unit.
// Assumes the unit on Avalon-MM and a pulled-down load on each pin.
`timescale 1ns/1ns
`default_nettype none
module test_dsp_top;
  import dsp_pkg::*;
  logic clk, rst_n, tick, slow, rd, wr, waitreq; // Clock, reset, tick, bus
  logic [4:0] adr; // Bus address
  logic [31:0] wdat, rdat; // Bus data
  logic [3:0] be; // Byte enables
  logic pin_a, oe_a, pin_b, oe_b, lvl_a, lvl_b; // Pins and pad levels
  logic [7:0] q; // Last read value
  logic [2:0] csel; // Clock select seen on the port
  int n_errors, checked, per, hi; // Counters and measurements
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} dsp_row_t;
  dsp_row_t rows[8]; // Write value and expected read back

  dsp_top i_dsp_top (.CLK_IN(clk), .RESET_N_IN(rst_n), .TIMER_TICK_IN(tick),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(waitreq), .CLK_SEL_OUT(csel), .WAVE_A_PIN_OUT(pin_a),
    .WAVE_A_OE_OUT(oe_a), .WAVE_B_PIN_OUT(pin_b), .WAVE_B_OE_OUT(oe_b));
  dsp_load i_dsp_load_a (.pin_in(pin_a), .oe_in(oe_a), .level_out(lvl_a));
  dsp_load i_dsp_load_b (.pin_in(pin_b), .oe_in(oe_b), .level_out(lvl_b));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Prescaler stand-in: every cycle, or every second cycle
  always @(posedge clk) tick <= slow ? ~tick : 1'b1;

  // Compare and count
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    begin
      checked++;
      if (s !== e)
      begin
        n_errors++;
        $display("wrong value %s expected %0h seen %0h", nm, e, s);
      end
    end
  endtask

  // One Avalon transfer; read data lands in q
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    begin
      n = 0;
      wr <= w;
      rd <= ~w;
      adr <= a;
      wdat <= {24'h0, d};
      do
      begin
        @(posedge clk);
        n++;
      end while (waitreq !== 1'b0 && n < 50);
      q = rdat[7:0];
      if (n >= 50) n_errors++;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic lv(input int sel);
    return sel ? lvl_b : lvl_a;
  endfunction

  // High time and period from one rising edge to the next
  task measure(input int sel, output int p, output int h);
    int n;
    begin
      n = 0;
      while (lv(sel) !== 1'b0 && n < 3000)
      begin
        @(posedge clk);
        n++;
      end
      while (lv(sel) !== 1'b1 && n < 6000)
      begin
        @(posedge clk);
        n++;
      end
      h = 0;
      while (lv(sel) === 1'b1 && h < 3000)
      begin
        @(posedge clk);
        h++;
      end
      p = h;
      while (lv(sel) === 1'b0 && p < 6000)
      begin
        @(posedge clk);
        p++;
      end
    end
  endtask

  // Count cycles where the pad leaves the expected level
  task steady(input int sel, input logic ex, input int n, output int bad);
    begin
      bad = 0;
      repeat (n)
      begin
        @(posedge clk);
        if (lv(sel) !== ex) bad++;
      end
    end
  endtask

  // Verdict and end of run
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Watchdog against a hung handshake or dead waveform
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wdat = 32'h0;
    be = 4'h1;
    slow = 1'b0;
    n_errors = 0;
    checked = 0;
    rows = '{'{OFS_CTRL_A, 8'hff, 8'hf3}, '{OFS_CTRL_A, 8'h00, 8'h00},
      '{OFS_CTRL_B, 8'hff, 8'h0f}, '{OFS_CTRL_B, 8'h00, 8'h00},
      '{OFS_CMP_A, 8'h5a, 8'h5a}, '{OFS_CMP_B, 8'ha5, 8'ha5},
      '{OFS_PINS, 8'h33, 8'h33}, '{5'h1c, 8'hff, 8'h00}};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, OFS_CTRL_A, 8'h00);
    check("ctrl_a reset", q, 8'h00);
    check("oe_a reset", oe_a, 1'b0);
    check("clock select reset", csel, 3'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 8'h00);
      check("register readback", q, rows[i].e);
    end
    be <= 4'h0;
    bus(1'b1, OFS_CTRL_A, 8'hc0);
    be <= 4'h1;
    bus(1'b0, OFS_CTRL_A, 8'h00);
    check("masked write", q, 8'h00);
    $display("test registers done");
    // Detached output shows the port data bit
    bus(1'b1, OFS_PINS, 8'h11);
    cyc(2);
    check("port level a", lvl_a, 1'b1);
    check("driver a", oe_a, 1'b1);
    bus(1'b1, OFS_PINS, 8'h10);
    cyc(2);
    check("undriven a", lvl_a, 1'b0);
    // Forced matches in normal mode: set, clear, toggle
    bus(1'b1, OFS_PINS, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, OFS_CTRL_A, {2'(3 - i), 6'h00});
      bus(1'b1, OFS_CTRL_B, 8'h80);
      cyc(2);
      check("forced a", lvl_a, logic'(i != 1));
    end
    $display("test port and force done");
    // Dual slope, TOP at MAX, non-inverted then inverted
    bus(1'b1, OFS_CMP_A, 8'h80);
    bus(1'b1, OFS_CTRL_A, 8'h81);
    bus(1'b1, OFS_CTRL_B, 8'h01);
    cyc(1100);
    measure(0, per, hi);
    check("dual period", per, 510);
    check("dual high", hi, 256);
    bus(1'b1, OFS_CTRL_A, 8'hc1);
    cyc(600);
    measure(0, per, hi);
    check("inverted high", hi, 254);
    bus(1'b1, OFS_FLAGS, 8'h07);
    cyc(600);
    bus(1'b0, OFS_FLAGS, 8'h00);
    check("overflow flag", q[OVF_BIT], 1'b1);
    bus(1'b1, OFS_CTRL_A, 8'h41);
    cyc(4);
    steady(0, 1'b0, 600, hi);
    check("toggle detached", hi, 0);
    $display("test dual slope done");
    // Extreme compare values on channel B
    bus(1'b1, OFS_CMP_B, 8'h00);
    bus(1'b1, OFS_CTRL_A, 8'h21);
    cyc(1100);
    steady(1, 1'b0, 600, hi);
    check("bottom low", hi, 0);
    bus(1'b1, OFS_CMP_B, 8'hff);
    cyc(1100);
    steady(1, 1'b1, 600, hi);
    check("max high", hi, 0);
    $display("test extremes done");
    // Dual slope with TOP from compare A
    bus(1'b1, OFS_CMP_A, 8'h40);
    bus(1'b1, OFS_CMP_B, 8'h20);
    bus(1'b1, OFS_CTRL_A, 8'h61);
    bus(1'b1, OFS_CTRL_B, 8'h09);
    check("clock select", csel, 3'h1);
    cyc(1100);
    measure(1, per, hi);
    check("var top period", per, 128);
    check("var top high", hi, 64);
    measure(0, per, hi);
    check("toggle period", per, 256);
    check("toggle high", hi, 128);
    // Single slope, TOP at MAX
    bus(1'b1, OFS_CMP_B, 8'h40);
    bus(1'b1, OFS_CTRL_A, 8'h23);
    bus(1'b1, OFS_CTRL_B, 8'h01);
    cyc(700);
    measure(1, per, hi);
    check("fast period", per, 256);
    check("fast high", hi, 65);
    $display("test top sources done");
    // Clear on match: toggle A every 16 ticks
    bus(1'b1, OFS_CTRL_A, 8'h42);
    bus(1'b1, OFS_CMP_A, 8'h0f);
    cyc(300);
    measure(0, per, hi);
    check("match toggle period", per, 32);
    check("match toggle high", hi, 16);
    $display("test clear on match done");
    // Tick every second cycle doubles the period
    slow <= 1'b1;
    bus(1'b1, OFS_CMP_A, 8'h80);
    bus(1'b1, OFS_CTRL_A, 8'h81);
    cyc(2200);
    measure(0, per, hi);
    check("slow period", per, 1020);
    check("slow high", hi, 512);
    $display("test prescaled done");
    report_and_stop;
  end
endmodule
`default_nettype wire
